// ===== core/sfw_defs.vh
// Purpose: Constants for the framed, width-selectable serial port.
// Assumes: Registers sit at their printed offsets on a 16-bit plain port.
// Notes:   Two port instances differ only in their three offsets.
//
// Overview of operation
// - Sixteen bits when width set, else eight.
// - Changing width resets the serial engine.
// - Output from bit 7 or bit 15.
// - Incoming data always enters bit 0.
// - Output disable releases the data output pin.
// - Framed mode turns select pin into sync.
// - Direction bit: sync is input or output.
// - Sync pulse high for one clock period.
// - Shifting starts at following transmit edge.
// - Selected slave works only while select low.
// - Select high releases output, restarts word.
// - Sleep shuts down and aborts transfers.
// - Sleep leaves all register contents intact.
// - Stop-in-idle bit chooses idle behaviour.
// - One address: write transmit, read receive.
// - Full receive buffer: overflow, drop, freeze.
// - Master clock is system/4 then prescaled.
// - Edge bit and idle polarity bit.
// - Master starts on write, flags at end of last bit.

`ifndef SFW_DEFS_VH
`define SFW_DEFS_VH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define SFW_P1_STAT 12'h220
`define SFW_P1_CON  12'h222
`define SFW_P1_BUF  12'h224
`define SFW_P2_STAT 12'h226
`define SFW_P2_CON  12'h228
`define SFW_P2_BUF  12'h22a

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define SFW_STAT_EN   15
`define SFW_STAT_SIDL 13
`define SFW_STAT_ROV  6
`define SFW_STAT_TBF  1
`define SFW_STAT_RBF  0
`define SFW_CON_FRM   14
`define SFW_CON_FSD   13
`define SFW_CON_DIS   11
`define SFW_CON_W16   10
`define SFW_CON_SMP   9
`define SFW_CON_CKE   8
`define SFW_CON_SELECT_PIN_ENABLE  7
`define SFW_CON_CKP   6
`define SFW_CON_MST   5
`define SFW_CON_MASK  16'h6fff
`define SFW_RST_VAL   16'h0000

// ****************************************************************
// Timing: the clock fed to the prescalers is system clock / 4,
// so one half serial period is (4 / 2) * primary * secondary.
// ****************************************************************
`define SFW_FOSC_DIV  15'h0004
`define SFW_SEC_BASE  4'h8

`endif

// ===== core/sfw_port.v
// Purpose: One serial port with 8/16-bit words, framing and select sync.
// Assumes: All pin inputs are synchronous to clk.
// Notes:   Registers are reached over a plain 16-bit strobe port.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defs.vh"

module sfw_port #(
  parameter [11:0] STAT_ADDR = `SFW_P1_STAT,
  parameter [11:0] CON_ADDR  = `SFW_P1_CON,
  parameter [11:0] BUF_ADDR  = `SFW_P1_BUF
) (
  input  wire        clk,                   // System clock.
  input  wire        resetn,                // Synchronous reset.
  input  wire [11:0] addr,                  // Register address.
  input  wire [15:0] wr_data,               // Write data.
  input  wire        wr_stb,                // Write strobe.
  input  wire        rd_stb,                // Read strobe.
  output wire [15:0] rd_data,               // Read data, next cycle.
  input  wire        cpu_sleep,             // CPU in Sleep.
  input  wire        cpu_idle,              // CPU in Idle.
  input  wire        shift_clock_pin_i,     // Serial clock in.
  output wire        shift_clock_pin_o,     // Serial clock out.
  output wire        shift_clock_pin_oe_n,  // Clock drive enable.
  input  wire        serial_data_in,        // Serial data in.
  output wire        serial_data_out,       // Serial data out.
  output wire        serial_data_out_oe_n,  // Data drive enable.
  input  wire        slave_select_pin_i,    // Select or sync in.
  output wire        slave_select_pin_o,    // Sync out.
  output wire        slave_select_pin_oe_n, // Sync drive enable.
  output wire        xfer_done              // Word event pulse.
);

  // ****************************************************************
  // Engine states.
  // ****************************************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WFS  = 4'h2;
  localparam [3:0] ST_SHF  = 4'h4;
  localparam [3:0] ST_TAIL = 4'h8;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  reg [15:0] con_q;
  reg        en_q;
  reg        sidl_q;
  reg        rov_q;
  reg        tbf_q;
  reg        rbf_q;
  reg [15:0] txb_q;
  reg [15:0] rxb_q;
  reg [15:0] sr_q;
  reg [15:0] wrd_q;
  reg        sdo_q;
  reg        sck_q;
  reg        fs_q;
  reg        sck_prev_q;
  reg [3:0]  st_q;
  reg [4:0]  bit_q;
  reg [10:0] div_q;
  reg        pend_q;
  reg [15:0] rd_data_q;
  reg        done_q;

  wire frm  = con_q[`SFW_CON_FRM];
  wire fsd  = con_q[`SFW_CON_FSD];
  wire dis  = con_q[`SFW_CON_DIS];
  wire w16  = con_q[`SFW_CON_W16];
  wire input_sample_phase  = con_q[`SFW_CON_SMP];
  wire cke  = con_q[`SFW_CON_CKE];
  wire select_pin_enable = con_q[`SFW_CON_SELECT_PIN_ENABLE];
  wire clock_idle_polarity  = con_q[`SFW_CON_CKP];
  wire mst  = con_q[`SFW_CON_MST];
  wire [2:0] secondary_prescale = con_q[4:2];
  wire [1:0] primary_prescale = con_q[1:0];

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire con_wr  = wr_stb & (addr == CON_ADDR);
  wire stat_wr = wr_stb & (addr == STAT_ADDR);
  wire buf_wr  = wr_stb & (addr == BUF_ADDR);
  wire buf_rd  = rd_stb & (addr == BUF_ADDR);

  // ****************************************************************
  // Stop and restart conditions.
  // ****************************************************************
  wire w16_chg = con_wr & (wr_data[`SFW_CON_W16] != w16);
  wire halt    = ~en_q | cpu_sleep | (cpu_idle & sidl_q);
  wire ss_off  = ~mst & select_pin_enable & ~frm & slave_select_pin_i;
  wire eng_rst = halt | w16_chg | ss_off;
  wire frozen  = rov_q & rbf_q;

  // ****************************************************************
  // Master clock divider.
  // ****************************************************************
  wire [1:0]  pp_inv = ~primary_prescale;
  wire [10:0] pdiv   = 11'h001 << {pp_inv, 1'b0};
  wire [3:0]  sdiv   = `SFW_SEC_BASE - {1'b0, secondary_prescale};
  wire [14:0] half_p = {4'h0, pdiv} * {11'h000, sdiv} * (`SFW_FOSC_DIV >> 1);
  wire [10:0] half_w = half_p[10:0] - 11'h001;
  wire        m_run  = mst & ~st_q[0];
  wire        tick   = m_run & ~frozen & (div_q == 11'h000);

  // ****************************************************************
  // Clock edge events, from own divider or the pin.
  // ****************************************************************
  wire m_lead  = tick & (sck_q == clock_idle_polarity) & ~st_q[3];
  wire m_trail = tick & (sck_q != clock_idle_polarity);
  wire s_chg   = ~mst & ~frozen & (shift_clock_pin_i != sck_prev_q);
  wire s_lead  = s_chg & (shift_clock_pin_i != clock_idle_polarity);
  wire s_trail = s_chg & (shift_clock_pin_i == clock_idle_polarity);
  wire lead    = m_lead | s_lead;
  wire trail   = m_trail | s_trail;
  wire tx_ev   = cke ? trail : lead;
  wire sm_ev   = cke ? lead : trail;
  wire act     = st_q[2] | st_q[3];
  wire smp_m   = mst & input_sample_phase;

  // End-phase sampling moves each capture to the next transmit edge.
  wire cap = act & (smp_m ? (pend_q & (tx_ev | (st_q[3] & tick))) : sm_ev);

  // ****************************************************************
  // Shift path.
  // ****************************************************************
  wire [15:0] sr_nxt = cap ? {sr_q[14:0], serial_data_in} : sr_q;
  wire [4:0]  nbits  = w16 ? 5'h10 : 5'h08;
  wire [3:0]  msb    = w16 ? 4'hf : 4'h7;
  wire        last   = sm_ev & st_q[2] & (bit_q == nbits - 5'h01);
  wire        compl  = mst ? (st_q[3] & tick) : last;
  wire [15:0] rx_w   = w16 ? sr_nxt : {8'h00, sr_nxt[7:0]};
  wire        rbf_e  = rbf_q & ~buf_rd;
  wire        fs_in  = fsd ? slave_select_pin_i : fs_q;

  // ****************************************************************
  // Registers and engine.
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn) begin
      con_q      <= `SFW_RST_VAL;
      en_q       <= 1'b0;
      sidl_q     <= 1'b0;
      rov_q      <= 1'b0;
      tbf_q      <= 1'b0;
      rbf_q      <= 1'b0;
      txb_q      <= `SFW_RST_VAL;
      rxb_q      <= `SFW_RST_VAL;
      sr_q       <= `SFW_RST_VAL;
      wrd_q      <= `SFW_RST_VAL;
      sdo_q      <= 1'b0;
      sck_q      <= 1'b0;
      fs_q       <= 1'b0;
      sck_prev_q <= 1'b0;
      st_q       <= ST_IDLE;
      bit_q      <= 5'h00;
      div_q      <= 11'h000;
      pend_q     <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      sck_prev_q <= shift_clock_pin_i;
      done_q     <= last & ~eng_rst;
      if (!m_run) begin
        div_q <= half_w;
      end else if (!frozen) begin
        div_q <= tick ? half_w : div_q - 11'h001;
      end
      if (eng_rst) begin
        // Abort only the engine; software-visible contents stay.
        st_q   <= ST_IDLE;
        bit_q  <= 5'h00;
        pend_q <= 1'b0;
        fs_q   <= 1'b0;
        sck_q  <= clock_idle_polarity;
        sr_q   <= wrd_q;
        sdo_q  <= wrd_q[msb];
      end else begin
        if (tick & ~(st_q[3] & (sck_q == clock_idle_polarity))) begin
          sck_q <= ~sck_q;
        end
        if (cap) begin
          sr_q <= sr_nxt;
        end
        if (act & tx_ev) begin
          sdo_q <= sr_nxt[msb];
        end
        if (smp_m & st_q[2] & sm_ev) begin
          pend_q <= 1'b1;
        end else if (cap) begin
          pend_q <= 1'b0;
        end
        case (st_q)
          ST_IDLE: begin
            sck_q <= clock_idle_polarity;
            bit_q <= 5'h00;
            if (!frozen & (tbf_q | ~mst)) begin
              st_q <= frm ? ST_WFS : ST_SHF;
              if (tbf_q) begin
                sr_q  <= txb_q;
                wrd_q <= txb_q;
                sdo_q <= txb_q[msb];
              end
            end
          end
          ST_WFS: begin
            if (sm_ev) begin
              if (fs_in & fsd) begin
                st_q <= ST_SHF;
              end else if (!fsd & fs_q) begin
                fs_q <= 1'b0;
                st_q <= ST_SHF;
              end else if (!fsd) begin
                fs_q <= 1'b1;
              end
            end
          end
          ST_SHF: begin
            if (sm_ev) begin
              bit_q <= bit_q + 5'h01;
            end
            if (last) begin
              st_q <= mst ? ST_TAIL : (frm ? ST_WFS : ST_SHF);
              bit_q <= 5'h00;
            end
          end
          ST_TAIL: begin
            if (tick) begin
              st_q <= ST_IDLE;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
        if (compl & tbf_q) begin
          sr_q  <= txb_q;
          wrd_q <= txb_q;
          sdo_q <= txb_q[msb];
        end
      end
      // Completion and status flags; a set beats a same-cycle clear.
      if (buf_rd) begin
        rbf_q <= 1'b0;
      end
      if (stat_wr) begin
        en_q   <= wr_data[`SFW_STAT_EN];
        sidl_q <= wr_data[`SFW_STAT_SIDL];
        rov_q  <= rov_q & wr_data[`SFW_STAT_ROV];
      end
      if (!eng_rst & compl) begin
        if (rbf_e) begin
          rov_q <= 1'b1;
        end else begin
          rxb_q <= rx_w;
          rbf_q <= 1'b1;
        end
        if (tbf_q) begin
          tbf_q <= 1'b0;
        end
      end
      if (!eng_rst & st_q[0] & ~frozen & tbf_q) begin
        tbf_q <= 1'b0;
      end
      if (con_wr) begin
        con_q <= wr_data & `SFW_CON_MASK;
      end
      if (buf_wr) begin
        txb_q <= wr_data;
        tbf_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read port: data stands only in the cycle after the strobe.
  // ****************************************************************
  always @(posedge clk) begin
    if (!resetn) begin
      rd_data_q <= `SFW_RST_VAL;
    end else if (rd_stb) begin
      if (addr == STAT_ADDR) begin
        rd_data_q <= {en_q, 1'b0, sidl_q, 6'h00, rov_q, 4'h0, tbf_q, rbf_q};
      end else if (addr == CON_ADDR) begin
        rd_data_q <= con_q;
      end else if (addr == BUF_ADDR) begin
        rd_data_q <= rxb_q;
      end else begin
        rd_data_q <= `SFW_RST_VAL;
      end
    end else begin
      rd_data_q <= `SFW_RST_VAL;
    end
  end

  // ****************************************************************
  // Pins.
  // ****************************************************************
  assign rd_data               = rd_data_q;
  assign xfer_done             = done_q;
  assign shift_clock_pin_o     = sck_q;
  assign shift_clock_pin_oe_n  = ~(~halt & mst);
  assign serial_data_out       = sdo_q;
  assign serial_data_out_oe_n  = ~(~halt & ~dis & ~ss_off);
  assign slave_select_pin_o    = fs_q;
  assign slave_select_pin_oe_n = ~(~halt & frm & ~fsd);

endmodule // sfw_port

`default_nettype wire

// ===== verif/sfw_chk.sv
// Purpose: Port-level checks for one serial port instance.
// Assumes: Mode bits are mirrored from bus writes.
// Notes:   Bound to every port instance.
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defs.vh"
module sfw_chk #(
  parameter [11:0] STAT_ADDR = `SFW_P1_STAT,
  parameter [11:0] CON_ADDR  = `SFW_P1_CON
) (
  input wire logic        clk,                   // System clock.
  input wire logic        resetn,                // Reset.
  input wire logic [11:0] addr,                  // Address.
  input wire logic [15:0] wr_data,               // Write data.
  input wire logic        wr_stb,                // Write strobe.
  input wire logic        rd_stb,                // Read strobe.
  input wire logic [15:0] rd_data,               // Read data.
  input wire logic        cpu_sleep,             // Sleep.
  input wire logic        cpu_idle,              // Idle.
  input wire logic        shift_clock_pin_o,     // Clock out.
  input wire logic        shift_clock_pin_oe_n,  // Clock enable.
  input wire logic        serial_data_out_oe_n,  // Data enable.
  input wire logic        slave_select_pin_i,    // Select in.
  input wire logic        slave_select_pin_o,    // Sync out.
  input wire logic        slave_select_pin_oe_n, // Sync enable.
  input wire logic        xfer_done              // Word event.
);
  logic        en_q;
  logic [15:0] con_q;
  always @(posedge clk) begin
    if (!resetn) begin
      en_q  <= 1'b0;
      con_q <= 16'h0000;
    end else if (wr_stb) begin
      if (addr == STAT_ADDR) en_q <= wr_data[15];
      if (addr == CON_ADDR) con_q <= wr_data & 16'h6fff;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_sleep2; cpu_sleep ##1 cpu_sleep; endsequence
  sequence s_fast_edge;
    $changed(shift_clock_pin_o) && en_q && con_q[5] && con_q[4:0] == 5'h1f;
  endsequence
  property p_rd_zero; !rd_stb |=> rd_data == 16'h0000; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
  property p_off;
    !en_q |-> shift_clock_pin_oe_n && serial_data_out_oe_n && slave_select_pin_oe_n;
  endproperty
  a_off: assert property (p_off) else $error("disabled port drives");
  property p_sleep; s_sleep2 |-> shift_clock_pin_oe_n && serial_data_out_oe_n; endproperty
  a_sleep: assert property (p_sleep) else $error("port drives in sleep");
  property p_dis_sdo; en_q && con_q[11] |-> serial_data_out_oe_n; endproperty
  a_dis_sdo: assert property (p_dis_sdo) else $error("disabled output driven");
  property p_master_oe;
    en_q && con_q[5] && !cpu_idle && !cpu_sleep && !$past(cpu_sleep) |-> !shift_clock_pin_oe_n;
  endproperty
  a_master_oe: assert property (p_master_oe) else $error("master clock undriven");
  property p_half; s_fast_edge |=> $stable(shift_clock_pin_o); endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  property p_done; xfer_done |=> !xfer_done; endproperty
  a_done: assert property (p_done) else $error("word event too long");
  property p_sync_off; !(en_q && con_q[14] && !con_q[13]) |-> slave_select_pin_oe_n; endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync driven wrongly");
  property p_sel_hi;
    en_q && !con_q[5] && con_q[7] && !con_q[14] && slave_select_pin_i |-> serial_data_out_oe_n;
  endproperty
  a_sel_hi: assert property (p_sel_hi) else $error("output driven unselected");
  sequence s_fs_hold; slave_select_pin_o[*4] ##1 !slave_select_pin_o; endsequence
  property p_fs_len;
    en_q && con_q[14] && !con_q[13] && con_q[5] && con_q[4:0] == 5'h1f &&
      !cpu_sleep && !cpu_idle && $rose(slave_select_pin_o) |-> s_fs_hold;
  endproperty
  a_fs_len: assert property (p_fs_len) else $error("sync pulse length wrong");
endmodule // sfw_chk
bind sfw_port sfw_chk #(.STAT_ADDR(STAT_ADDR), .CON_ADDR(CON_ADDR)) sfw_chk_inst (
  .clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_data(rd_data), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
  .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe_n(shift_clock_pin_oe_n),
  .serial_data_out_oe_n(serial_data_out_oe_n), .slave_select_pin_i(slave_select_pin_i),
  .slave_select_pin_o(slave_select_pin_o),
  .slave_select_pin_oe_n(slave_select_pin_oe_n), .xfer_done(xfer_done));
`default_nettype wire

// ===== verif/sfw_slave_model.sv
// Purpose: Behavioural serial slave facing a master port.
// Assumes: Idle-low clock, sample on rising edge, change on falling edge.
// Notes:   After its word the data line carries a changing pattern.
`timescale 1ns/1ps
`default_nettype none
module sfw_slave_model (
  input  wire logic        sck,  // Serial clock.
  input  wire logic        sdo,  // Data from the port.
  input  wire logic        w16,  // Sixteen-bit words.
  input  wire logic        load, // Load reply word.
  input  wire logic [15:0] word, // Reply word.
  output var  logic        sdi,  // Data to the port.
  output var  logic [15:0] got   // Bits taken in.
);
  logic [15:0] sh_q = 16'h0000;
  initial got = 16'h0000;
  assign sdi = w16 ? sh_q[15] : sh_q[7];
  always @(posedge sck) got <= {got[14:0], sdo};
  always @(negedge sck or posedge load) begin
    if (load) sh_q <= word;
    else sh_q <= {sh_q[14:0], ~sh_q[0]};
  end
endmodule // sfw_slave_model
`default_nettype wire

// ===== verif/sfw_port_test.sv
// Purpose: Self-checking bench for one serial port.
// Assumes: Port 1 offsets; slave model on the serial side.
// Notes:   Reads are checked by a queue-driven monitor.
`timescale 1ns/1ps
`default_nettype none
`include "sfw_defs.vh"
module sfw_port_test;
  logic        clk = 0, resetn = 0, wr_stb = 0, rd_stb = 0, rd_pend = 0;
  logic        cpu_sleep = 0, cpu_idle = 0, ssel = 1, load = 0, w16 = 0, sck_in = 0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wr_data = 16'h0000, pw = 16'h0000, d, p, m;
  logic [15:0] q[$];
  wire  [15:0] rd_data, got;
  wire         sck, sck_oe_n, sdi, sdo, sdo_oe_n, ss_o, ss_oe_n, done;
  int          n_mismatch = 0, cmp_count = 0, w;
  integer      seed;
  sfw_port sfw_port_inst (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .cpu_sleep(cpu_sleep),
    .cpu_idle(cpu_idle), .shift_clock_pin_i(sck_in), .shift_clock_pin_o(sck),
    .shift_clock_pin_oe_n(sck_oe_n), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_out_oe_n(sdo_oe_n), .slave_select_pin_i(ssel), .slave_select_pin_o(ss_o),
    .slave_select_pin_oe_n(ss_oe_n), .xfer_done(done));
  sfw_slave_model sfw_slave_model_inst (.sck(sck), .sdo(sdo), .w16(w16), .load(load),
    .word(pw), .sdi(sdi), .got(got));
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk) begin
    rd_pend <= rd_stb;
    if (rd_pend) chk(rd_data, q.pop_front());
  end
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk);
    addr    <= a;
    wr_data <= v;
    wr_stb  <= 1'b1;
    @(posedge clk);
    wr_stb  <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] v);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    q.push_back(v);
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask
  task automatic ld(input logic [15:0] v);
    @(posedge clk);
    pw   <= v;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  // Toggles the slave-role clock pin n times, each level held two cycles.
  task automatic sclk(input int n);
    repeat (n) begin
      @(posedge clk);
      sck_in <= ~sck_in;
      @(posedge clk);
    end
  endtask
  task automatic xfer(input logic [15:0] dv, input logic [15:0] pv);
    int i;
    ld(pv);
    wr(`SFW_P1_BUF, dv);
    for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
    chk(i < 400, 16'h0001);
    repeat (4) @(posedge clk);
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    seed = 32'h9f948cd3;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(`SFW_P1_STAT, 16'h0000);
    rd(`SFW_P1_BUF, 16'h0000);
    wr(`SFW_P1_CON, 16'hffff);
    rd(`SFW_P1_CON, 16'h6fff);
    rd(12'h22c, 16'h0000);
    for (w = 0; w < 2; w++) begin
      wr(`SFW_P1_STAT, 16'h0000);
      wr(`SFW_P1_CON, {5'h00, w[0], 10'h13f});
      w16 <= w[0];
      wr(`SFW_P1_STAT, 16'h8000);
      d = $random(seed);
      p = $random(seed);
      m = w[0] ? 16'hffff : 16'h00ff;
      xfer(d, p);
      chk(got & m, d & m);
      rd(`SFW_P1_STAT, 16'h8001);
      rd(`SFW_P1_BUF, p & m);
    end
    xfer(d, p);
    xfer(~d, ~p);
    rd(`SFW_P1_STAT, 16'h8041);
    rd(`SFW_P1_BUF, p);
    rd(`SFW_P1_STAT, 16'h8040);
    wr(`SFW_P1_STAT, 16'h8000);
    rd(`SFW_P1_STAT, 16'h8000);
    wr(`SFW_P1_STAT, 16'h0000);
    wr(`SFW_P1_CON, 16'h093b);
    w16 <= 1'b0;
    wr(`SFW_P1_STAT, 16'h8000);
    wr(`SFW_P1_BUF, d);
    repeat (10) @(posedge clk);
    cpu_sleep <= 1'b1;
    repeat (5) @(posedge clk);
    cpu_sleep <= 1'b0;
    rd(`SFW_P1_CON, 16'h093b);
    rd(`SFW_P1_STAT, 16'h8000);
    xfer(d, p);
    rd(`SFW_P1_BUF, p & 16'h00ff);
    wr(`SFW_P1_STAT, 16'h0000);
    wr(`SFW_P1_CON, 16'h0080);
    wr(`SFW_P1_STAT, 16'h8000);
    ld(16'h0000);
    repeat (3) @(negedge clk);
    chk({15'h0000, sdo_oe_n}, 16'h0001);
    @(posedge clk);
    ssel <= 1'b0;
    repeat (3) @(negedge clk);
    chk({15'h0000, sdo_oe_n}, 16'h0000);
    // Three zero bits, then deselect: the word must restart from scratch.
    sclk(6);
    @(posedge clk);
    ssel <= 1'b1;
    ld(16'hffff);
    ssel <= 1'b0;
    repeat (2) @(posedge clk);
    sclk(16);
    repeat (3) @(posedge clk);
    rd(`SFW_P1_STAT, 16'h8001);
    rd(`SFW_P1_BUF, 16'h00ff);
    // Framed master with generated sync; alternating reply survives the two sync clocks.
    wr(`SFW_P1_STAT, 16'h0000);
    wr(`SFW_P1_CON, 16'h413f);
    wr(`SFW_P1_STAT, 16'h8000);
    @(negedge clk);
    chk({15'h0000, ss_oe_n}, 16'h0000);
    xfer(d, 16'haaaa);
    chk(got & 16'h00ff, d & 16'h00ff);
    rd(`SFW_P1_BUF, 16'h00aa);
    cpu_idle <= 1'b1;
    repeat (2) @(negedge clk);
    chk({15'h0000, sck_oe_n}, 16'h0000);
    wr(`SFW_P1_STAT, 16'ha000);
    @(negedge clk);
    chk({15'h0000, sck_oe_n}, 16'h0001);
    rd(`SFW_P1_STAT, 16'ha000);
    final_report;
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end
endmodule // sfw_port_test
`default_nettype wire
